//--- pkg/ira_defines.svh
// Constants of the interrupt routing and auto-sleep block
// Summary of operation
// - A source reaches the interrupt logic only while its enable bit is set.
// - Routing bit 0 sends an enabled source to pin b, 1 to pin a.
// - All enabled sources routed to one pin are ORed together.
// - With sleep enabled, the inactivity count sets the idle time before sleep rate.
// - One count unit is 320 ms, or 640 ms at the slowest rate.
// - Enabled events other than sleep and data-ready restart inactivity timing; sleep and data-ready do not.
// - Enabled motion-type events with wake bit set leave sleep; fifo never wakes.
// - Only previously enabled sources restart timing or wake the device.
// - A restarting event before expiry cancels sleep and clears the counter.
// - No restarting event within the period enters sleep mode.
// - Flags held off in sleep return on wake, except data-ready.
// - Enabled sleep interrupt is raised on every mode change both ways.
// - With fifo gate set, mode change keeps fifo, sets error, blocks samples.
// - Pins are active low with polarity 0, active high with 1.
// - Pins drive push-pull with drive bit 0, open-drain with 1.
// - Gate error stays set until the fifo has been emptied.
`ifndef IRA_DEFINES_SVH
`define IRA_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define IRA_ADDR_SLEEP_COUNT  8'h29
`define IRA_ADDR_INT_ENABLE   8'h2d
`define IRA_ADDR_INT_ROUTING  8'h2e
`define IRA_REG_RESET         8'h00

// ****************************************
// Event bit positions
// ****************************************
`define IRA_BIT_SLEEP   7
`define IRA_BIT_FIFO    6
`define IRA_BIT_TRANS   5
`define IRA_BIT_ORIENT  4
`define IRA_BIT_TAP     3
`define IRA_BIT_FALL    2
`define IRA_BIT_VECM    1
`define IRA_BIT_DRDY    0
`define IRA_RESTART_MASK 8'h7e
`define IRA_WAKE_MASK    8'h3e

// ****************************************
// Timing
// ****************************************
`define IRA_CLK_KHZ       20000
`define IRA_STEP_MS       320
`define IRA_STEP_LONG_MS  640
`define IRA_STEP_CYC      (`IRA_CLK_KHZ * `IRA_STEP_MS)
`define IRA_STEP_LONG_CYC (`IRA_CLK_KHZ * `IRA_STEP_LONG_MS)
`define IRA_RATE_SLOWEST  3'h7

`endif

//--- pkg/ira_pkg.sv
// Types of the interrupt routing and auto-sleep block
package ira_pkg;
  typedef enum logic {
    MODE_ACTIVE,
    MODE_SLEEP
  } ira_mode_e;
  typedef logic [7:0] ira_byte_t;
endpackage

//--- rtl/ira_sleep_timer.sv
// Inactivity timer that measures idle time in count units
`include "ira_defines.svh"
module ira_sleep_timer #(
  parameter int STEP_CYC = `IRA_STEP_CYC,
  parameter int LONG_CYC = `IRA_STEP_LONG_CYC
) (
  input  wire logic        clk,       // System clock
  input  wire logic        rst_n,     // Synchronised reset, active low
  input  wire logic        run,       // Timing allowed
  input  wire logic        restart,   // Restarting event seen
  input  wire logic        long_step, // Slowest rate selected
  input  wire logic [7:0]  count,     // Programmed idle units
  output logic             expired    // Idle period reached
);
  logic [23:0] pre_r;
  logic [7:0]  units_r;
  logic [23:0] pre_top;

  // Unit length depends on the active rate
  assign pre_top = long_step ? 24'(LONG_CYC - 1) : 24'(STEP_CYC - 1);

  // Prescaler and unit counter, cleared on restart or when not running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r   <= 24'h000000;
      units_r <= 8'h00;
    end else if (!run || restart) begin
      pre_r   <= 24'h000000;
      units_r <= 8'h00;
    end else if (pre_r >= pre_top) begin
      pre_r <= 24'h000000;
      if (units_r != 8'hff) begin
        units_r <= units_r + 8'h01;
      end
    end else begin
      pre_r <= pre_r + 24'h000001;
    end
  end

  // Expiry once the unit count reaches the programmed value
  assign expired = run && (units_r >= count);
endmodule // ira_sleep_timer

//--- rtl/ira_irq_router.sv
// Interrupt combiner with polarity and drive mode shared by both pins
module ira_irq_router (
  input  wire logic       clk,      // System clock
  input  wire logic       rst_n,    // Synchronised reset, active low
  input  wire logic [7:0] flags,    // Event flags
  input  wire logic [7:0] en,       // Effective enables
  input  wire logic [7:0] route,    // 1 pin a, 0 pin b
  input  wire logic       ipol,     // 1 active high
  input  wire logic       od,       // 1 open-drain
  output logic            pin_a_o,  // Pin a output value
  output logic            pin_a_oe, // Pin a output enable
  output logic            pin_b_o,  // Pin b output value
  output logic            pin_b_oe  // Pin b output enable
);
  logic hit_a;
  logic hit_b;
  logic lvl_a;
  logic lvl_b;

  // OR of enabled flags per pin, then polarity
  assign hit_a = |(flags & en & route);
  assign hit_b = |(flags & en & ~route);
  assign lvl_a = ipol ? hit_a : ~hit_a;
  assign lvl_b = ipol ? hit_b : ~hit_b;

  // Pin drivers updated every clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_o  <= 1'b1;
      pin_a_oe <= 1'b1;
      pin_b_o  <= 1'b1;
      pin_b_oe <= 1'b1;
    end else begin
      pin_a_o  <= od ? 1'b0 : lvl_a;
      pin_a_oe <= od ? ~lvl_a : 1'b1;
      pin_b_o  <= od ? 1'b0 : lvl_b;
      pin_b_oe <= od ? ~lvl_b : 1'b1;
    end
  end
endmodule // ira_irq_router

//--- rtl/ira_top.sv
// Interrupt routing and auto-sleep controller top
`include "ira_defines.svh"
module ira_top #(
  parameter int STEP_CYC = `IRA_STEP_CYC,
  parameter int LONG_CYC = `IRA_STEP_LONG_CYC
) (
  input  wire logic       ref_clk,            // System clock, 20 MHz
  input  wire logic       arst_n,             // Asynchronous reset, active low
  input  wire logic       reg_wr_en,          // Register write strobe
  input  wire logic [7:0] reg_addr,           // Register address
  input  wire logic [7:0] reg_wdata,          // Register write data
  output logic      [7:0] reg_rdata,          // Register read data
  input  wire logic [6:0] event_flags,        // Detector flags, fifo..data-ready
  input  wire logic [7:0] wake_ctrl,          // Wake enables at event positions
  input  wire logic       sleep_enable,       // Auto-sleep enable
  input  wire logic [2:0] active_rate_select, // Active rate code
  input  wire logic       ipol,               // Pin polarity, 1 active high
  input  wire logic       irq_output_drive,   // 1 open-drain
  input  wire logic       fifo_gate,          // Keep fifo on mode change
  input  wire logic       fifo_empty,         // Fifo holds no samples
  input  wire logic       sleep_event_clear,  // Host read of sleep source
  output logic            irq_pin_a_o,        // Pin a value
  output logic            irq_pin_a_oe,       // Pin a enable
  output logic            irq_pin_b_o,        // Pin b value
  output logic            irq_pin_b_oe,       // Pin b enable
  output logic            sleep_mode,         // Sleep rate in use
  output logic            sleep_wake_event,   // Sticky sleep/wake flag
  output logic            fifo_gate_error,    // Gate error, samples blocked
  output logic            fifo_flush          // Flush pulse on mode change with fifo gate clear
);
  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_r;
  logic       rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************
  // Registers
  // ****************************************
  ira_pkg::ira_byte_t sleep_count_r;
  ira_pkg::ira_byte_t int_en_r;
  ira_pkg::ira_byte_t int_route_r;

  // Register writes at the printed offsets
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_count_r <= `IRA_REG_RESET;
      int_en_r      <= `IRA_REG_RESET;
      int_route_r   <= `IRA_REG_RESET;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `IRA_ADDR_SLEEP_COUNT: sleep_count_r <= reg_wdata;
        `IRA_ADDR_INT_ENABLE:  int_en_r      <= reg_wdata;
        `IRA_ADDR_INT_ROUTING: int_route_r   <= reg_wdata;
        default:               int_en_r      <= int_en_r;
      endcase
    end
  end

  // Read data, zero for unmapped addresses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `IRA_ADDR_SLEEP_COUNT: reg_rdata <= sleep_count_r;
        `IRA_ADDR_INT_ENABLE:  reg_rdata <= int_en_r;
        `IRA_ADDR_INT_ROUTING: reg_rdata <= int_route_r;
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Event qualification
  // ****************************************
  ira_pkg::ira_mode_e mode_r;
  ira_pkg::ira_mode_e mode_nxt;
  logic               sleep_evt_r;
  logic               drdy_hold_r;
  logic [7:0]         all_flags;
  logic [7:0]         suppress;
  logic [7:0]         en_eff;
  logic               restart;
  logic               wake;
  logic               expired;
  logic               change;

  // Full event vector with the internal sleep/wake flag on top
  assign all_flags = {sleep_evt_r, event_flags};

  // Sleep holds off motion detectors without wake enable, data-ready stays off
  assign suppress = ((mode_r == ira_pkg::MODE_SLEEP) ? (`IRA_WAKE_MASK & ~wake_ctrl)
                    : 8'h00) | {7'h00, drdy_hold_r};
  assign en_eff   = int_en_r & ~suppress;

  // Restart and wake consider only enabled sources
  assign restart = |(all_flags & int_en_r & `IRA_RESTART_MASK);
  assign wake    = |(all_flags & int_en_r & wake_ctrl & `IRA_WAKE_MASK);

  // ****************************************
  // Mode control
  // ****************************************
  ira_sleep_timer #(
    .STEP_CYC (STEP_CYC),
    .LONG_CYC (LONG_CYC)
  ) u_timer (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .run       ((mode_r == ira_pkg::MODE_ACTIVE) && sleep_enable),
    .restart   (restart),
    .long_step (active_rate_select == `IRA_RATE_SLOWEST),
    .count     (sleep_count_r),
    .expired   (expired)
  );

  // Next mode from expiry and wake events
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      ira_pkg::MODE_ACTIVE: begin
        if (sleep_enable && expired && !restart) begin
          mode_nxt = ira_pkg::MODE_SLEEP;
        end
      end
      ira_pkg::MODE_SLEEP: begin
        if (wake || !sleep_enable) begin
          mode_nxt = ira_pkg::MODE_ACTIVE;
        end
      end
      default: mode_nxt = ira_pkg::MODE_ACTIVE;
    endcase
  end
  assign change = (mode_nxt != mode_r);

  // Mode state and its output copy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r     <= ira_pkg::MODE_ACTIVE;
      sleep_mode <= 1'b0;
    end else begin
      mode_r     <= mode_nxt;
      sleep_mode <= (mode_nxt == ira_pkg::MODE_SLEEP);
    end
  end

  // Sticky sleep/wake flag, a new change wins over the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_evt_r <= 1'b0;
    end else if (change && int_en_r[`IRA_BIT_SLEEP]) begin
      sleep_evt_r <= 1'b1;
    end else if (sleep_event_clear) begin
      sleep_evt_r <= 1'b0;
    end
  end
  assign sleep_wake_event = sleep_evt_r;

  // Data-ready stays off after sleep until the enable register is written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drdy_hold_r <= 1'b0;
    end else if (mode_nxt == ira_pkg::MODE_SLEEP && change) begin
      drdy_hold_r <= 1'b1;
    end else if (reg_wr_en && reg_addr == `IRA_ADDR_INT_ENABLE) begin
      drdy_hold_r <= 1'b0;
    end
  end

  // Fifo gate error or flush on each mode change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_gate_error <= 1'b0;
      fifo_flush      <= 1'b0;
    end else begin
      fifo_flush <= change && !fifo_gate;
      if (change && fifo_gate) begin
        fifo_gate_error <= 1'b1;
      end else if (fifo_empty) begin
        fifo_gate_error <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pin logic
  // ****************************************
  ira_irq_router u_router (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .flags    (all_flags),
    .en       (en_eff),
    .route    (int_route_r),
    .ipol     (ipol),
    .od       (irq_output_drive),
    .pin_a_o  (irq_pin_a_o),
    .pin_a_oe (irq_pin_a_oe),
    .pin_b_o  (irq_pin_b_o),
    .pin_b_oe (irq_pin_b_oe)
  );

  // ****************************************
  // Checks
  // ****************************************
  logic ipol_q;
  logic od_q;
  logic act_a;
  logic act_b;

  // Settings of the previous cycle, to decode pin activity
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ipol_q <= 1'b0;
      od_q   <= 1'b0;
    end else begin
      ipol_q <= ipol;
      od_q   <= irq_output_drive;
    end
  end
  assign act_a = od_q ? (ipol_q ? !irq_pin_a_oe : irq_pin_a_oe) : (irq_pin_a_o == ipol_q);
  assign act_b = od_q ? (ipol_q ? !irq_pin_b_oe : irq_pin_b_oe) : (irq_pin_b_o == ipol_q);

  // Pin and mode checks
  a_enable_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (int_en_r == 8'h00) |=> (!act_a && !act_b))
    else $error("pin active with all enables clear");
  a_route_pin_b: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 (act_b == $past(|(all_flags & en_eff & ~int_route_r))))
    else $error("pin b does not follow routed flags");
  a_route_or_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 (act_a == $past(|(all_flags & en_eff & int_route_r))))
    else $error("pin a is not the OR of routed flags");
  a_polarity_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!ipol && !irq_output_drive && !(|(all_flags & en_eff))) |=> (irq_pin_a_o && irq_pin_b_o))
    else $error("idle active-low pin not high");
  a_drive_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq_output_drive |=> (!irq_pin_a_o && !irq_pin_b_o))
    else $error("open-drain pin drives high");
  a_restart_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_r == ira_pkg::MODE_ACTIVE && restart) |=> (mode_r == ira_pkg::MODE_ACTIVE) [*2])
    else $error("sleep entered despite restarting event");
  a_sleep_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_r == ira_pkg::MODE_ACTIVE && sleep_enable && expired && !restart)
    |=> (mode_r == ira_pkg::MODE_SLEEP && sleep_mode))
    else $error("sleep not entered on expiry");
  a_wake_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_r == ira_pkg::MODE_SLEEP && sleep_enable)
    |=> (mode_r == ira_pkg::MODE_ACTIVE) == $past(wake))
    else $error("wake decision wrong");
  a_sleep_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (change && int_en_r[`IRA_BIT_SLEEP]) |=> sleep_evt_r)
    else $error("mode change did not raise sleep flag");
  a_gate_error: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (change && fifo_gate) |=> (fifo_gate_error && !fifo_flush))
    else $error("gated change did not set gate error");
  a_drdy_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_r == ira_pkg::MODE_SLEEP) |-> !en_eff[`IRA_BIT_DRDY])
    else $error("data-ready enabled during sleep");

  // Fifo, flag, counter, register and push-pull checks
  a_flush_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (change && !fifo_gate) |=> fifo_flush)
    else $error("ungated change did not flush");
  a_gate_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fifo_gate_error && !fifo_empty) |=> fifo_gate_error)
    else $error("gate error dropped before fifo emptied");
  a_gate_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fifo_empty && !(change && fifo_gate)) |=> !fifo_gate_error)
    else $error("gate error kept after fifo emptied");
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sleep_event_clear && !(change && int_en_r[`IRA_BIT_SLEEP])) |=> !sleep_evt_r)
    else $error("sleep flag not cleared by source read");
  a_restart_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (restart && !reg_wr_en && sleep_count_r != 8'h00) |=> !expired)
    else $error("restart did not clear the sleep counter");
  a_rdata_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_addr == `IRA_ADDR_INT_ENABLE) |=> (reg_rdata == $past(int_en_r)))
    else $error("enable register read wrong");
  a_push_pull: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !irq_output_drive |=> (irq_pin_a_oe && irq_pin_b_oe))
    else $error("push-pull pin not driven");

  // Main scenarios reached
  c_sleep_entry: cover property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_r == ira_pkg::MODE_ACTIVE) ##1 (mode_r == ira_pkg::MODE_SLEEP));
  c_wake_exit: cover property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_r == ira_pkg::MODE_SLEEP) && wake);
  c_both_pins: cover property (@(posedge ref_clk) disable iff (!rst_n)
    act_a && act_b);
  c_gated_change: cover property (@(posedge ref_clk) disable iff (!rst_n)
    change && fifo_gate);
  c_restart_cancel: cover property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_r == ira_pkg::MODE_ACTIVE) && sleep_enable && restart);
endmodule // ira_top

//--- bench/ira_host_model.sv
// Host model: resolves the interrupt wires, reads the source flag and empties the fifo
module ira_host_model (
  input  wire logic       clk,         // System clock
  input  wire logic       pin_a_o,     // Pin a value
  input  wire logic       pin_a_oe,    // Pin a enable
  input  wire logic       pin_b_o,     // Pin b value
  input  wire logic       pin_b_oe,    // Pin b enable
  input  wire logic       ipol,        // 1 active high
  input  wire logic       gate_error,  // Fifo gate error from the device
  input  wire logic       sleep_flag,  // Sticky sleep/wake flag
  input  wire logic       ack_en,      // Host may service the interrupt
  input  wire logic [7:0] drain_delay, // Cycles taken to empty the fifo
  output logic            wire_a,      // Resolved pin a level
  output logic            wire_b,      // Resolved pin b level
  output logic            irq_a,       // Pin a asserted
  output logic            irq_b,       // Pin b asserted
  output logic            fifo_empty,  // Fifo holds no samples
  output logic            src_read     // Source read pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Wires and host actions
  // ********************
  int drain_cnt;
  // A released line floats to the pull-up level
  assign wire_a = pin_a_oe ? pin_a_o : 1'b1;
  assign wire_b = pin_b_oe ? pin_b_o : 1'b1;
  assign irq_a  = (wire_a === ipol);
  assign irq_b  = (wire_b === ipol);
  // Start with samples held and no read under way
  initial begin
    fifo_empty = 1'b0;
    src_read   = 1'b0;
    drain_cnt  = 0;
  end
  // Read the source register while the sticky flag stands
  always @(posedge clk) begin
    src_read <= ack_en && (sleep_flag === 1'b1) && !src_read;
  end
  // Empty the fifo some cycles after a gated mode change
  always @(posedge clk) begin
    if (gate_error === 1'b1 && !fifo_empty) begin
      if (drain_cnt >= int'(drain_delay)) begin
        fifo_empty <= 1'b1;
      end else begin
        drain_cnt <= drain_cnt + 1;
      end
    end else if (gate_error !== 1'b1) begin
      fifo_empty <= 1'b0;
      drain_cnt  <= 0;
    end
  end
endmodule  // ira_host_model

//--- bench/test_irq_route_and_autosleep.sv
// Self-checking bench for the interrupt routing and auto-sleep block
module test_irq_route_and_autosleep;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 4;
  localparam int LONG = 8;
  logic       ref_clk, arst_n, reg_wr_en, sleep_enable, ipol, irq_output_drive, fifo_gate;
  logic       fifo_empty, sleep_event_clear, irq_pin_a_o, irq_pin_a_oe, irq_pin_b_o;
  logic       irq_pin_b_oe, sleep_mode, sleep_wake_event, fifo_gate_error, fifo_flush;
  logic       wire_a, wire_b, irq_a, irq_b, ack_en, flush_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, wake_ctrl, drain_delay;
  logic [6:0] event_flags;
  logic [2:0] active_rate_select;
  int         errors = 0, samples_checked = 0, n;
  ira_top #(.STEP_CYC(STEP), .LONG_CYC(LONG)) u_ira_top (
    .ref_clk, .arst_n, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .event_flags,
    .wake_ctrl, .sleep_enable, .active_rate_select, .ipol, .irq_output_drive, .fifo_gate,
    .fifo_empty, .sleep_event_clear, .irq_pin_a_o, .irq_pin_a_oe, .irq_pin_b_o,
    .irq_pin_b_oe, .sleep_mode, .sleep_wake_event, .fifo_gate_error, .fifo_flush);
  ira_host_model u_ira_host_model (
    .clk(ref_clk), .pin_a_o(irq_pin_a_o), .pin_a_oe(irq_pin_a_oe), .pin_b_o(irq_pin_b_o),
    .pin_b_oe(irq_pin_b_oe), .ipol, .gate_error(fifo_gate_error),
    .sleep_flag(sleep_wake_event), .ack_en, .drain_delay, .wire_a, .wire_b, .irq_a, .irq_b,
    .fifo_empty, .src_read(sleep_event_clear));
  // ********************
  // Clock, monitors and helpers
  // ********************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Remember any flush pulse
  always @(posedge ref_clk) if (fifo_flush === 1'b1) flush_seen <= 1'b1;
  task automatic chk1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int lo, input int hi, input string what);
    samples_checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("MISMATCH %0t %s got %0d cycles", $time, what, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic settle();
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    settle();
    chk8(reg_rdata, exp, "read");
  endtask
  task automatic flags(input logic [6:0] f);
    @(posedge ref_clk);
    event_flags <= f;
    settle();
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (s !== v && n < lim);
    chk1(s, v, "wait");
  endtask
  task automatic ack();
    ack_en <= 1'b1;
    wait_for(sleep_wake_event, 1'b0, 8);
    ack_en <= 1'b0;
    settle();
    chk1(irq_a | irq_b, 1'b0, "flag read clears pin");
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_regs();
    rd(8'h29, 8'h00);
    rd(8'h2d, 8'h00);
    rd(8'h2e, 8'h00);
    chk1(irq_a | irq_b, 1'b0, "idle pins");
    chk1(irq_pin_a_oe & irq_pin_b_oe, 1'b1, "push-pull");
    wr(8'h29, 8'ha5);
    wr(8'h2d, 8'h5a);
    wr(8'h2e, 8'hc3);
    wr(8'h30, 8'hff);
    rd(8'h29, 8'ha5);
    rd(8'h2d, 8'h5a);
    rd(8'h2e, 8'hc3);
    rd(8'h30, 8'h00);
  endtask
  task automatic t_route();
    for (int b = 0; b < 7; b++) begin
      for (int r = 0; r < 2; r++) begin
        wr(8'h2d, 8'h00);
        wr(8'h2e, 8'(r << b));
        flags(7'(1 << b));
        chk1(irq_a | irq_b, 1'b0, "disabled source");
        wr(8'h2d, 8'(1 << b));
        settle();
        chk1(irq_a, 1'(r), "pin a route");
        chk1(irq_b, 1'(r == 0), "pin b route");
        flags(7'h00);
      end
    end
    wr(8'h2e, 8'h28);
    wr(8'h2d, 8'h28);
    flags(7'h28);
    flags(7'h08);
    chk1(irq_a, 1'b1, "or of two");
    flags(7'h00);
    chk1(irq_a, 1'b0, "or released");
  endtask
  task automatic t_pins();
    logic [2:0] m;
    logic       lv;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      @(posedge ref_clk);
      ipol             <= m[0];
      irq_output_drive <= m[1];
      flags({1'b0, m[2], 5'h00});
      lv = m[2] ~^ m[0];
      chk1(irq_a, m[2], "asserted");
      chk1(irq_pin_a_o, m[1] ? 1'b0 : lv, "pin value");
      chk1(irq_pin_a_oe, m[1] ? !lv : 1'b1, "pin enable");
    end
    @(posedge ref_clk);
    ipol             <= 1'b0;
    irq_output_drive <= 1'b0;
    flags(7'h00);
  endtask
  task automatic t_sleep();
    int unit;
    wr(8'h29, 8'h02);
    wr(8'h2d, 8'h80);
    wr(8'h2e, 8'h80);
    for (int k = 0; k < 2; k++) begin
      unit = k ? LONG : STEP;
      flush_seen <= 1'b0;
      @(posedge ref_clk);
      active_rate_select <= k ? 3'h7 : 3'h0;
      sleep_enable       <= 1'b1;
      wait_for(sleep_mode, 1'b1, 40);
      chkn(n, 2 * unit - 1, 2 * unit + 4, "idle time");
      chk1(sleep_wake_event, 1'b1, "sleep flag");
      settle();
      chk1(irq_a, 1'b1, "sleep irq");
      chk1(flush_seen, 1'b1, "flush on sleep");
      ack();
      @(posedge ref_clk);
      sleep_enable <= 1'b0;
      wait_for(sleep_mode, 1'b0, 8);
      chk1(sleep_wake_event, 1'b1, "wake flag");
      ack();
    end
  endtask
  task automatic t_wake();
    wr(8'h2d, 8'he1);
    wr(8'h2e, 8'h01);
    flags(7'h21);
    @(posedge ref_clk);
    active_rate_select <= 3'h0;
    sleep_enable       <= 1'b1;
    repeat (30) @(negedge ref_clk);
    chk1(sleep_mode, 1'b0, "held awake");
    flags(7'h09);
    wait_for(sleep_mode, 1'b1, 40);
    chkn(n, 2 * STEP - 3, 2 * STEP + 4, "restart cleared");
    settle();
    chk1(irq_a, 1'b0, "ready masked asleep");
    flags(7'h49);
    repeat (10) @(negedge ref_clk);
    chk1(sleep_mode, 1'b1, "buffer event no wake");
    flags(7'h29);
    repeat (10) @(negedge ref_clk);
    chk1(sleep_mode, 1'b1, "wake bit clear");
    @(posedge ref_clk);
    wake_ctrl <= 8'h20;
    wait_for(sleep_mode, 1'b0, 8);
    settle();
    chk1(irq_a, 1'b0, "ready stays off");
    wr(8'h2d, 8'he1);
    settle();
    chk1(irq_a, 1'b1, "ready restored");
    @(posedge ref_clk);
    sleep_enable <= 1'b0;
    wake_ctrl    <= 8'h00;
    event_flags  <= 7'h00;
    ack();
  endtask
  task automatic t_gate();
    wr(8'h29, 8'h00);
    wr(8'h2d, 8'h80);
    @(posedge ref_clk);
    fifo_gate   <= 1'b1;
    drain_delay <= 8'h0a;
    flush_seen  <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      sleep_enable <= 1'(k == 0);
      wait_for(fifo_gate_error, 1'b1, 40);
      chk1(sleep_mode, 1'(k == 0), "gated change");
      repeat (5) @(negedge ref_clk);
      chk1(fifo_gate_error, 1'b1, "error holds");
      wait_for(fifo_gate_error, 1'b0, 20);
    end
    chk1(flush_seen, 1'b0, "no flush gated");
    ack();
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence: reset for 20 cycles, then every scenario
  initial begin
    arst_n = 1'b0;  reg_wr_en = 1'b0;  reg_addr = 8'h00;  reg_wdata = 8'h00;
    event_flags = 7'h00;  wake_ctrl = 8'h00;  sleep_enable = 1'b0;  ipol = 1'b0;
    active_rate_select = 3'h0;  irq_output_drive = 1'b0;  fifo_gate = 1'b0;
    ack_en = 1'b0;  drain_delay = 8'h00;  flush_seen = 1'b0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_route();
    t_pins();
    t_sleep();
    t_wake();
    t_gate();
    report_and_stop();
  end
  // Watchdog: the scenarios need well under 3000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end
endmodule  // test_irq_route_and_autosleep
